/* src/port_pin_control.v */
// Function
// - Second-port pull-up on bits 5,2,1,0 connects only when enabled and the pin is input or open drain.
// - Second-port readback on bits 5,2,1,0 gives the pin in input or open-drain mode, else zero.
// - Second-port readback bits 4 and 3 always give the pin level.
// - Each of the eight fourth-port pins has its own direction bit.
// - A fourth-port output pin drives its latch bit; latch bits reset to zero.
// - Fourth-port direction 0 is input and feeds the analog channel, 1 is output; reset is zero.
// - The fourth-port pull-up is usable only in input mode.
// - An enabled key wakeup makes the pin a wakeup input whatever its direction bit.
// - An enabled key wakeup works whatever the function-select bit.
// - Second-port open drain with latch 1 releases the pin instead of driving high.
// - Fourth-port pull-up connects when enabled and wakeup is on or function and direction are 0.
// - Fourth-port readback gives the pin only when direction and function are 0, else zero.
`timescale 1ns/100ps
`include "port_pin_map.vh"

module port_pin_control (
  input  wire        clk,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [13:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [5:0]  second_port_pin_in,
  output wire [5:0]  second_port_pin_out,
  output wire [5:0]  second_port_pin_oe,
  output wire [5:0]  second_port_pullup_on,
  input  wire [7:0]  fourth_port_pin_in,
  output wire [7:0]  fourth_port_pin_out,
  output wire [7:0]  fourth_port_pin_oe,
  output wire [7:0]  fourth_port_pullup_on,
  input  wire [7:0]  key_wakeup_pin_enable,
  output wire [7:0]  analog_channel_select,
  output wire [7:0]  key_wakeup_input
);

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  function hit;
    input [13:0] addr;
    input [11:0] index;
    begin
      hit = (addr[13:2] == index) && (addr[1:0] == 2'b00);
    end
  endfunction

  // ------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------
  reg  [5:0] second_port_output_latch;
  reg  [5:0] second_port_direction;
  reg  [5:0] second_port_driver_type;
  reg  [5:0] second_port_pullup_enable;
  reg  [7:0] fourth_port_output_latch;
  reg  [7:0] fourth_port_direction;
  reg  [7:0] fourth_port_function_select;
  reg  [7:0] fourth_port_pullup_enable;

  wire [7:0] second_port_pin_readback;
  wire [7:0] fourth_port_pin_readback;

  wire       access;
  wire       write_commit;
  reg        mapped;
  reg  [7:0] next_read;

  // ------------------------------------------------------------
  // APB handshake
  // ------------------------------------------------------------
  // One wait state: pready rises in the second access cycle
  assign access       = psel & penable & ~pready;
  assign write_commit = psel & penable & pready & pwrite;

  always @* begin
    mapped    = 1'b1;
    next_read = 8'h00;
    if (hit(paddr, `IDX_P2_LATCH)) begin
      next_read = {2'b00, second_port_output_latch};
    end else if (hit(paddr, `IDX_P2_DIRECTION)) begin
      next_read = {2'b00, second_port_direction};
    end else if (hit(paddr, `IDX_P2_DRIVER)) begin
      next_read = {2'b00, second_port_driver_type};
    end else if (hit(paddr, `IDX_P2_PULLUP)) begin
      next_read = {2'b00, second_port_pullup_enable};
    end else if (hit(paddr, `IDX_P2_READBACK)) begin
      next_read = second_port_pin_readback;
    end else if (hit(paddr, `IDX_P4_LATCH)) begin
      next_read = fourth_port_output_latch;
    end else if (hit(paddr, `IDX_P4_DIRECTION)) begin
      next_read = fourth_port_direction;
    end else if (hit(paddr, `IDX_P4_FUNCTION)) begin
      next_read = fourth_port_function_select;
    end else if (hit(paddr, `IDX_P4_PULLUP)) begin
      next_read = fourth_port_pullup_enable;
    end else if (hit(paddr, `IDX_P4_READBACK)) begin
      next_read = fourth_port_pin_readback;
    end else begin
      mapped    = 1'b0;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= access;
      pslverr <= access & ~mapped;
      if (access & ~pwrite) begin
        prdata <= {24'h000000, next_read};
      end
    end
  end

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  // Writes to the readback registers are ignored
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      second_port_output_latch    <= `RST_P2_LATCH;
      second_port_direction       <= `RST_P2_DIRECTION;
      second_port_driver_type     <= `RST_P2_DRIVER;
      second_port_pullup_enable   <= `RST_P2_PULLUP;
      fourth_port_output_latch    <= `RST_P4_LATCH;
      fourth_port_direction       <= `RST_P4_DIRECTION;
      fourth_port_function_select <= `RST_P4_FUNCTION;
      fourth_port_pullup_enable   <= `RST_P4_PULLUP;
    end else if (write_commit) begin
      if (hit(paddr, `IDX_P2_LATCH)) begin
        second_port_output_latch <= pwdata[5:0];
      end
      if (hit(paddr, `IDX_P2_DIRECTION)) begin
        second_port_direction <= pwdata[5:0];
      end
      if (hit(paddr, `IDX_P2_DRIVER)) begin
        second_port_driver_type <= pwdata[5:0] & `P2_OD_BITS;
      end
      if (hit(paddr, `IDX_P2_PULLUP)) begin
        second_port_pullup_enable <= pwdata[5:0] & `P2_OD_BITS;
      end
      if (hit(paddr, `IDX_P4_LATCH)) begin
        fourth_port_output_latch <= pwdata[7:0];
      end
      if (hit(paddr, `IDX_P4_DIRECTION)) begin
        fourth_port_direction <= pwdata[7:0];
      end
      if (hit(paddr, `IDX_P4_FUNCTION)) begin
        fourth_port_function_select <= pwdata[7:0];
      end
      if (hit(paddr, `IDX_P4_PULLUP)) begin
        fourth_port_pullup_enable <= pwdata[7:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Second port pins
  // ------------------------------------------------------------
  port2_pin_logic u_port2 (
    .clk           (clk),
    .rst           (rst),
    .direction     (second_port_direction),
    .latch         (second_port_output_latch),
    .driver_type   (second_port_driver_type),
    .pullup_enable (second_port_pullup_enable),
    .pin_in        (second_port_pin_in),
    .pin_out       (second_port_pin_out),
    .pin_oe        (second_port_pin_oe),
    .pullup_on     (second_port_pullup_on),
    .readback      (second_port_pin_readback)
  );

  // ------------------------------------------------------------
  // Fourth port pins
  // ------------------------------------------------------------
  port4_pin_logic u_port4 (
    .clk                   (clk),
    .rst                   (rst),
    .direction             (fourth_port_direction),
    .latch                 (fourth_port_output_latch),
    .function_select       (fourth_port_function_select),
    .pullup_enable         (fourth_port_pullup_enable),
    .key_wakeup_pin_enable (key_wakeup_pin_enable),
    .pin_in                (fourth_port_pin_in),
    .pin_out               (fourth_port_pin_out),
    .pin_oe                (fourth_port_pin_oe),
    .pullup_on             (fourth_port_pullup_on),
    .readback              (fourth_port_pin_readback),
    .analog_channel_select (analog_channel_select),
    .key_wakeup_input      (key_wakeup_input)
  );

endmodule

/* src/port_pin_map.vh */
`ifndef PORT_PIN_MAP_VH
`define PORT_PIN_MAP_VH

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define IDX_P2_LATCH      12'h002
`define IDX_P4_LATCH      12'h004
`define IDX_P2_READBACK   12'h00F
`define IDX_P4_READBACK   12'h011
`define IDX_P2_DIRECTION  12'hF1C
`define IDX_P4_DIRECTION  12'hF1E
`define IDX_P2_PULLUP     12'hF29
`define IDX_P4_PULLUP     12'hF2B
`define IDX_P4_FUNCTION   12'hF38
`define IDX_P2_DRIVER     12'hF43

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RST_P2_LATCH      6'h00
`define RST_P2_DIRECTION  6'h00
`define RST_P2_DRIVER     6'h00
`define RST_P2_PULLUP     6'h00
`define RST_P4_LATCH      8'h00
`define RST_P4_DIRECTION  8'h00
`define RST_P4_FUNCTION   8'h00
`define RST_P4_PULLUP     8'h00

// ------------------------------------------------------------
// Field layout
// ------------------------------------------------------------
`define P2_WIDTH          6
`define P4_WIDTH          8
`define P2_OD_BITS        6'h27

`endif

/* src/port2_pin_logic.v */
`timescale 1ns/100ps
`include "port_pin_map.vh"

module port2_pin_logic (
  input  wire       clk,
  input  wire       rst,
  input  wire [5:0] direction,
  input  wire [5:0] latch,
  input  wire [5:0] driver_type,
  input  wire [5:0] pullup_enable,
  input  wire [5:0] pin_in,
  output reg  [5:0] pin_out,
  output reg  [5:0] pin_oe,
  output reg  [5:0] pullup_on,
  output reg  [7:0] readback
);

  // ------------------------------------------------------------
  // Pin driver, pull-up and readback
  // ------------------------------------------------------------
  wire [5:0] open_drain;
  wire [5:0] released;
  wire [5:0] next_pin_out;
  wire [5:0] next_pin_oe;
  wire [5:0] next_pullup_on;
  wire [7:0] next_readback;

  // Bits 4 and 3 have no open-drain option
  assign open_drain     = driver_type & `P2_OD_BITS;
  assign released       = ~direction | open_drain;
  // Open drain drives only low; a latch 1 releases the pin
  assign next_pin_oe    = direction & ~(open_drain & latch);
  assign next_pin_out   = latch & ~open_drain;
  assign next_pullup_on = pullup_enable & `P2_OD_BITS & released;
  assign next_readback  = {2'b00, pin_in & (released | ~`P2_OD_BITS)};

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_out   <= 6'h00;
      pin_oe    <= 6'h00;
      pullup_on <= 6'h00;
      readback  <= 8'h00;
    end else begin
      pin_out   <= next_pin_out;
      pin_oe    <= next_pin_oe;
      pullup_on <= next_pullup_on;
      readback  <= next_readback;
    end
  end

endmodule

/* src/port4_pin_logic.v */
`timescale 1ns/100ps
`include "port_pin_map.vh"

module port4_pin_logic (
  input  wire       clk,
  input  wire       rst,
  input  wire [7:0] direction,
  input  wire [7:0] latch,
  input  wire [7:0] function_select,
  input  wire [7:0] pullup_enable,
  input  wire [7:0] key_wakeup_pin_enable,
  input  wire [7:0] pin_in,
  output reg  [7:0] pin_out,
  output reg  [7:0] pin_oe,
  output reg  [7:0] pullup_on,
  output reg  [7:0] readback,
  output reg  [7:0] analog_channel_select,
  output reg  [7:0] key_wakeup_input
);

  // ------------------------------------------------------------
  // Pin driver, pull-up, readback and secondary functions
  // ------------------------------------------------------------
  wire [7:0] port_input;
  wire [7:0] next_pin_oe;
  wire [7:0] next_pullup_on;
  wire [7:0] next_analog;

  assign port_input     = ~direction & ~function_select;
  // Analog use or key wakeup keeps the driver off
  assign next_pin_oe    = direction & ~function_select
                          & ~key_wakeup_pin_enable;
  assign next_pullup_on = pullup_enable
                          & (key_wakeup_pin_enable | port_input);
  assign next_analog    = function_select | ~direction;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_out               <= 8'h00;
      pin_oe                <= 8'h00;
      pullup_on             <= 8'h00;
      readback              <= 8'h00;
      analog_channel_select <= 8'h00;
      key_wakeup_input      <= 8'h00;
    end else begin
      pin_out               <= latch;
      pin_oe                <= next_pin_oe;
      pullup_on             <= next_pullup_on;
      readback              <= pin_in & port_input;
      analog_channel_select <= next_analog;
      key_wakeup_input      <= pin_in & key_wakeup_pin_enable;
    end
  end

endmodule

/* testbench/port_pin_control_monitor.sv */
`timescale 1ns/100ps
module port_pin_control_monitor (
  input wire        clk,
  input wire        rst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [13:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire [5:0]  second_port_pin_in,
  input wire [5:0]  second_port_pin_out,
  input wire [5:0]  second_port_pin_oe,
  input wire [5:0]  second_port_pullup_on,
  input wire [7:0]  fourth_port_pin_in,
  input wire [7:0]  fourth_port_pin_out,
  input wire [7:0]  fourth_port_pin_oe,
  input wire [7:0]  fourth_port_pullup_on,
  input wire [7:0]  key_wakeup_pin_enable,
  input wire [7:0]  analog_channel_select,
  input wire [7:0]  key_wakeup_input
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_p2_pull_gate: assert property ((second_port_pullup_on
    & second_port_pin_oe & second_port_pin_out) == 6'h00)
    else $error("pull-up on a push-pull high pin");
  a_p2_pull_bits: assert property (second_port_pullup_on[4:3] == 2'b00)
    else $error("pull-up on bit 4 or 3");
  a_p4_pull_input: assert property ((fourth_port_pullup_on
    & fourth_port_pin_oe) == 8'h00)
    else $error("pull-up on a driven pin");
  a_p4_wake_input: assert property (!$past(rst) |->
    ($past(key_wakeup_pin_enable) & fourth_port_pin_oe) == 8'h00)
    else $error("wakeup pin driven");
  a_wake_level: assert property (!$past(rst) |-> key_wakeup_input
    == $past(fourth_port_pin_in & key_wakeup_pin_enable))
    else $error("wakeup input wrong");
  a_analog_no_drive: assert property ((analog_channel_select
    & fourth_port_pin_oe) == 8'h00)
    else $error("analog pin driven");
  a_input_analog: assert property (!$past(rst) && !$past(rst, 2) |->
    (~fourth_port_pin_oe & ~$past(key_wakeup_pin_enable)
     & ~analog_channel_select) == 8'h00)
    else $error("input pin not on analog channel");
  c_write: cover property (pready && pwrite);
  c_error: cover property (pslverr);
  c_wake: cover property (|key_wakeup_input);
endmodule
bind port_pin_control port_pin_control_monitor mon (.clk(clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .second_port_pin_in(second_port_pin_in),
  .second_port_pin_out(second_port_pin_out),
  .second_port_pin_oe(second_port_pin_oe),
  .second_port_pullup_on(second_port_pullup_on),
  .fourth_port_pin_in(fourth_port_pin_in),
  .fourth_port_pin_out(fourth_port_pin_out),
  .fourth_port_pin_oe(fourth_port_pin_oe),
  .fourth_port_pullup_on(fourth_port_pullup_on),
  .key_wakeup_pin_enable(key_wakeup_pin_enable),
  .analog_channel_select(analog_channel_select),
  .key_wakeup_input(key_wakeup_input));

/* testbench/board_pins.sv */
`timescale 1ns/100ps
module board_pins #(parameter int N = 8) (
  input  wire          clk,
  input  wire  [N-1:0] out,
  input  wire  [N-1:0] oe,
  input  wire  [N-1:0] pull,
  input  wire  [N-1:0] drv,
  input  wire  [N-1:0] drv_en,
  output logic [N-1:0] level
);
  // Undriven, unpulled pins wander every cycle
  logic [N-1:0] float_bits = '0;
  always @(posedge clk) float_bits <= ~float_bits;
  always_comb begin
    for (int i = 0; i < N; i++) begin
      level[i] = oe[i] ? out[i] : drv_en[i] ? drv[i]
               : pull[i] ? 1'b1 : float_bits[i];
    end
  end
endmodule

/* testbench/test_port_pin_control_p2_p4.sv */
`timescale 1ns/100ps
`include "port_pin_map.vh"
module test_port_pin_control_p2_p4;
  logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [13:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, err;
  logic [5:0]  p2_in, p2_out, p2_oe, p2_pu, p2_drv = '0, p2_den = '0;
  logic [7:0]  p4_in, p4_out, p4_oe, p4_pu, p4_drv = '0, p4_den = '0;
  logic [7:0]  wake = '0, ana, kwi;
  int          miscompares = 0, checks = 0, cyc = 0;
  port_pin_control uut (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .second_port_pin_in(p2_in), .second_port_pin_out(p2_out),
    .second_port_pin_oe(p2_oe), .second_port_pullup_on(p2_pu),
    .fourth_port_pin_in(p4_in), .fourth_port_pin_out(p4_out),
    .fourth_port_pin_oe(p4_oe), .fourth_port_pullup_on(p4_pu),
    .key_wakeup_pin_enable(wake), .analog_channel_select(ana),
    .key_wakeup_input(kwi));
  board_pins #(.N(6)) p2_board (.clk(clk), .out(p2_out), .oe(p2_oe),
    .pull(p2_pu), .drv(p2_drv), .drv_en(p2_den), .level(p2_in));
  board_pins #(.N(8)) p4_board (.clk(clk), .out(p4_out), .oe(p4_oe),
    .pull(p4_pu), .drv(p4_drv), .drv_en(p4_den), .level(p4_in));
  initial forever #2.5 clk = ~clk;
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      final_report;
    end
  end
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic apb(logic wr, logic [11:0] idx, logic [31:0] wd);
    @(posedge clk);
    psel <= 1; pwrite <= wr; paddr <= {idx, 2'b00}; pwdata <= wd;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rdc(string name, logic [11:0] idx, logic [31:0] exp);
    apb(0, idx, 32'h0);
    chk(name, exp, rd);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    logic [11:0] regs[8] = '{`IDX_P2_LATCH, `IDX_P4_LATCH,
      `IDX_P2_DIRECTION, `IDX_P4_DIRECTION, `IDX_P2_PULLUP,
      `IDX_P4_PULLUP, `IDX_P4_FUNCTION, `IDX_P2_DRIVER};
    foreach (regs[i]) rdc("reset value", regs[i], 32'h0);
  endtask
  task automatic t_bus;
    apb(1, `IDX_P2_DRIVER, 32'hFF);
    rdc("driver mask", `IDX_P2_DRIVER, 32'h27);
    apb(1, 12'h100, 32'hFF);
    chk("unmapped error", 32'h1, {31'h0, err});
  endtask
  task automatic t_port2;
    apb(1, `IDX_P2_DIRECTION, 32'h3F);
    apb(1, `IDX_P2_LATCH, 32'h3F);
    apb(1, `IDX_P2_PULLUP, 32'hFF);
    repeat (3) @(posedge clk);
    chk("p2 oe open drain", 32'h18, p2_oe);
    chk("p2 out open drain", 32'h18, p2_out);
    chk("p2 pull open drain", 32'h27, p2_pu);
    rdc("p2 read open drain", `IDX_P2_READBACK, 32'h3F);
    apb(1, `IDX_P2_DRIVER, 32'h0);
    repeat (3) @(posedge clk);
    chk("p2 pull push pull", 32'h0, p2_pu);
    chk("p2 oe push pull", 32'h3F, p2_oe);
    chk("p2 out push pull", 32'h3F, p2_out);
    rdc("p2 read push pull", `IDX_P2_READBACK, 32'h18);
    p2_drv <= 6'h15;
    p2_den <= 6'h3F;
    apb(1, `IDX_P2_DIRECTION, 32'h0);
    repeat (3) @(posedge clk);
    rdc("p2 read input", `IDX_P2_READBACK, 32'h15);
  endtask
  task automatic t_port4;
    wake <= 8'h01;
    p4_drv <= 8'hFF;
    p4_den <= 8'hFF;
    apb(1, `IDX_P4_DIRECTION, 32'hF1);
    apb(1, `IDX_P4_LATCH, 32'hA5);
    apb(1, `IDX_P4_FUNCTION, 32'h30);
    apb(1, `IDX_P4_PULLUP, 32'hFF);
    repeat (3) @(posedge clk);
    chk("p4 oe", 32'hC0, p4_oe);
    chk("p4 out", 32'hA5, p4_out);
    chk("p4 pull", 32'h0F, p4_pu);
    chk("p4 analog", 32'h3E, ana);
    chk("p4 wakeup", 32'h01, kwi);
    rdc("p4 read", `IDX_P4_READBACK, 32'h0E);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    t_reset;
    t_bus;
    t_port2;
    t_port4;
    final_report;
  end
endmodule
